// ===== include/aqp_pkg.sv
package aqp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int AQP_CLOCK_HZ      = 25_000_000;
  localparam int AQP_PULSE_HZ      = 100_000;
  localparam int AQP_CYC_PER_PULSE = AQP_CLOCK_HZ / AQP_PULSE_HZ;
  localparam int AQP_GAP_US        = 100;
  localparam int AQP_GAP_CYC       = AQP_GAP_US * (AQP_CLOCK_HZ / 1_000_000);

  // edge accumulator: four quadrature edges per pulse period
  localparam logic [8:0] AQP_ACC_STEP = 9'h004;
  localparam logic [8:0] AQP_ACC_WRAP = 9'(AQP_CYC_PER_PULSE);

  // ----------------------------------------------------------------
  // position format
  // ----------------------------------------------------------------
  localparam int AQP_POS_BITS       = 13;
  localparam int AQP_TURN_BITS      = 13;
  localparam int AQP_PULSES_PER_REV = 2048;
  localparam int AQP_WORD_BITS      = AQP_TURN_BITS + AQP_POS_BITS;
  localparam logic [12:0] AQP_POS_MAX      = 13'h1fff;
  localparam logic [12:0] AQP_TURN_POS_MAX = 13'h0fff;
  localparam logic [12:0] AQP_TURN_NEG_MIN = 13'h1000;
  localparam logic [1:0]  AQP_AB_RESET     = 2'h0;

  // ----------------------------------------------------------------
  // link supervision and buffering
  // ----------------------------------------------------------------
  localparam logic [2:0] AQP_LINK_MISS_LIMIT = 3'h4;
  localparam int         AQP_FIFO_DEPTH      = 16;

  typedef enum logic [5:0] {
    AQP_WAIT  = 6'h01,
    AQP_TURNS = 6'h02,
    AQP_GAP1  = 6'h04,
    AQP_POS   = 6'h08,
    AQP_GAP2  = 6'h10,
    AQP_INC   = 6'h20
  } aqp_state_type;

  // one quadrature step on {a,b}; forward makes a lead b
  function automatic logic [1:0] aqp_step(input logic [1:0] ab, input logic forward_rotation);
    logic [1:0] r;
    r = ab;
    case (ab)
      2'h0:    r = forward_rotation ? 2'h2 : 2'h1;
      2'h2:    r = forward_rotation ? 2'h3 : 2'h0;
      2'h3:    r = forward_rotation ? 2'h1 : 2'h2;
      default: r = forward_rotation ? 2'h0 : 2'h3;
    endcase
    return r;
  endfunction

  function automatic logic [12:0] aqp_mag(input logic [12:0] t);
    return t[12] ? (~t + 13'h0001) : t;
  endfunction

endpackage

// ===== include/aqp_stream_if.sv
`timescale 1ns/1ns
interface aqp_stream_if #(parameter int W = 26) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/aqp_fifo.sv
`timescale 1ns/1ns
module aqp_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 16
) (
  input  wire logic clock,
  input  wire logic srst,
  aqp_stream_if.snk wr,
  aqp_stream_if.src rd,
  output logic      full,
  output logic      empty
);
  // depth must be a power of two; pointers wrap naturally
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign full     = cnt_ff == (AW+1)'(DEPTH);
  assign empty    = cnt_ff == '0;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_ff[rptr_ff];
  assign push     = wr.valid && !full;
  assign pop      = rd.ready && !empty;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wptr_ff] <= wr.data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (push) wptr_ff <= wptr_ff + 1'b1;
      if (pop)  rptr_ff <= rptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ===== rtl/aqp_position_output.sv
// Behaviour
// - single-turn position and turn counter are each held in 13 bits.
// - encoder samples queue in a 16-deep buffer while bursts run; a full buffer back-pressures the link.
// - first power-up after battery install raises the system failure alarm.
// - the turn data clear command clears a pending system failure alarm.
// - after power-up send turn count then position once, unrequested.
// - after the position bursts, output follows shaft motion incrementally.
// - turn burst: A leads B for positive count, lags for negative.
// - burst quadrature pulses run at a fixed 100 kHz.
// - position burst: A leads B when turns positive, lags when negative.
// - incremental: A leads B forward, lags B in reverse.
// - incremental: 2048 pulses on each of A and B per revolution.
// - one index pulse on Z per revolution, width unspecified.
// - four consecutive failed encoder exchanges raise the link error alarm.
`timescale 1ns/1ns
module aqp_position_output
  import aqp_pkg::*;
#(
  parameter int FIFO_DEPTH = AQP_FIFO_DEPTH,
  parameter int GAP_CYC    = AQP_GAP_CYC
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        first_power_strap,
  input  wire logic        turn_data_clear_command,
  input  wire logic        enc_valid,
  input  wire logic [12:0] enc_turns,
  input  wire logic [12:0] enc_pos,
  output logic             enc_ready,
  input  wire logic        enc_exchange,
  input  wire logic        enc_rx_ok,
  output logic             phase_a,
  output logic             phase_b,
  output logic             phase_z,
  output logic             position_sent,
  output logic             system_failure_alarm,
  output logic             turn_counter_overflow_alarm,
  output logic             encoder_link_error_alarm
);

  // ------------------------------------------------------------------
  // sample buffer
  // ------------------------------------------------------------------
  aqp_stream_if #(.W(AQP_WORD_BITS)) enc_in ();
  aqp_stream_if #(.W(AQP_WORD_BITS)) enc_out ();

  logic fifo_full;

  assign enc_in.valid = enc_valid;
  assign enc_in.data  = {enc_turns, enc_pos};
  assign enc_ready    = enc_in.ready;

  // bursts stall the drain, so samples pile up here and back-pressure the link
  aqp_fifo #(.W(AQP_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock (clock),
    .srst  (srst),
    .wr    (enc_in),
    .rd    (enc_out),
    .full  (fifo_full),
    .empty ()
  );

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  aqp_state_type state_ff;
  aqp_state_type nxt_state;
  logic [7:0]    acc_ff;
  logic [8:0]    acc_sum;
  logic          tick;
  logic [14:0]   rem_ff;
  logic [11:0]   gap_ff;
  logic          gap_done;
  logic [1:0]    ab_ff;
  logic          z_ff;
  logic [12:0]   tur_ff;
  logic [12:0]   cur_ff;
  logic [12:0]   tgt_ff;
  logic [12:0]   diff;
  logic [12:0]   in_turns;
  logic [12:0]   in_pos;
  logic          pop;
  logic          in_burst;
  logic          burst_step;
  logic          turn_neg;
  logic          inc_fwd;
  logic          inc_step;
  logic          boot_ff;
  logic          sfa_ff;
  logic          ovf_ff;
  logic [2:0]    miss_ff;
  logic          link_ff;
  logic [14:0]   edge_cnt_ff;

  assign in_turns   = enc_out.data[AQP_WORD_BITS-1:AQP_POS_BITS];
  assign in_pos     = enc_out.data[AQP_POS_BITS-1:0];
  assign pop        = enc_out.valid && enc_out.ready;
  assign turn_neg   = tur_ff[12];
  assign in_burst   = (state_ff == AQP_TURNS) || (state_ff == AQP_POS);
  assign burst_step = in_burst && tick && (rem_ff != '0);
  assign diff       = tgt_ff - cur_ff;
  assign inc_fwd    = !diff[12];
  assign inc_step   = (state_ff == AQP_INC) && tick && (cur_ff != tgt_ff);
  assign gap_done   = gap_ff == 12'(GAP_CYC - 1);

  // drain only while idle-waiting or once the last target is reached
  assign enc_out.ready = (state_ff == AQP_WAIT) ||
                         ((state_ff == AQP_INC) && (cur_ff == tgt_ff));

  assign phase_a                     = ab_ff[1];
  assign phase_b                     = ab_ff[0];
  assign phase_z                     = z_ff;
  assign position_sent               = state_ff == AQP_INC;
  assign system_failure_alarm        = sfa_ff;
  assign turn_counter_overflow_alarm = ovf_ff;
  assign encoder_link_error_alarm    = link_ff;

  // ------------------------------------------------------------------
  // edge timebase
  // ------------------------------------------------------------------
  // fractional accumulator: exact 100 kHz, edges 62 or 63 cycles apart
  assign acc_sum = {1'b0, acc_ff} + AQP_ACC_STEP;
  assign tick    = acc_sum >= AQP_ACC_WRAP;

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_ff <= '0;
    end else if (tick) begin
      acc_ff <= 8'(acc_sum - AQP_ACC_WRAP);
    end else begin
      acc_ff <= acc_sum[7:0];
    end
  end

  // ------------------------------------------------------------------
  // output sequence
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      AQP_WAIT:  if (enc_out.valid) nxt_state = AQP_TURNS;
      AQP_TURNS: if (rem_ff == '0) nxt_state = AQP_GAP1;
      AQP_GAP1:  if (gap_done) nxt_state = AQP_POS;
      AQP_POS:   if (rem_ff == '0) nxt_state = AQP_GAP2;
      AQP_GAP2:  if (gap_done) nxt_state = AQP_INC;
      AQP_INC:   nxt_state = AQP_INC;
      default:   nxt_state = AQP_WAIT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= AQP_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // remaining edges of the current burst
  always_ff @(posedge clock) begin
    if (srst) begin
      rem_ff <= '0;
    end else if ((state_ff == AQP_WAIT) && pop) begin
      rem_ff <= {aqp_mag(in_turns), 2'h0};
    end else if ((state_ff == AQP_GAP1) && gap_done) begin
      rem_ff <= {2'h0, cur_ff};
    end else if (burst_step) begin
      rem_ff <= rem_ff - 15'h0001;
    end
  end

  // quiet time so the host can see where each burst ends
  always_ff @(posedge clock) begin
    if (srst) begin
      gap_ff <= '0;
    end else if ((state_ff == AQP_GAP1) || (state_ff == AQP_GAP2)) begin
      gap_ff <= gap_done ? 12'h000 : gap_ff + 12'h001;
    end else begin
      gap_ff <= '0;
    end
  end

  // ------------------------------------------------------------------
  // quadrature and index outputs
  // ------------------------------------------------------------------
  // both bursts take their phase order from the turn count sign
  always_ff @(posedge clock) begin
    if (srst) begin
      ab_ff <= AQP_AB_RESET;
    end else if (burst_step) begin
      ab_ff <= aqp_step(ab_ff, !turn_neg);
    end else if (inc_step) begin
      ab_ff <= aqp_step(ab_ff, inc_fwd);
    end
  end

  // index over the first quadrature cycle of the turn; width is not promised
  always_ff @(posedge clock) begin
    if (srst) begin
      z_ff <= 1'b0;
    end else begin
      z_ff <= (state_ff == AQP_INC) && (cur_ff[12:2] == 11'h000);
    end
  end

  // ------------------------------------------------------------------
  // position tracking
  // ------------------------------------------------------------------
  // 8192 edges per turn: 2048 quadrature pulses on each phase
  always_ff @(posedge clock) begin
    if (srst) begin
      tur_ff <= '0;
      cur_ff <= '0;
      tgt_ff <= '0;
    end else if ((state_ff == AQP_WAIT) && pop) begin
      tur_ff <= in_turns;
      cur_ff <= in_pos;
      tgt_ff <= in_pos;
    end else if (pop) begin
      tgt_ff <= in_pos;
    end else if (inc_step && inc_fwd) begin
      cur_ff <= cur_ff + 13'h0001;
      if (cur_ff == AQP_POS_MAX) tur_ff <= tur_ff + 13'h0001;
    end else if (inc_step) begin
      cur_ff <= cur_ff - 13'h0001;
      if (cur_ff == '0) tur_ff <= tur_ff - 13'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ovf_ff <= 1'b0;
    end else if (inc_step && inc_fwd && (cur_ff == AQP_POS_MAX) &&
                 (tur_ff == AQP_TURN_POS_MAX)) begin
      ovf_ff <= 1'b1;
    end else if (inc_step && !inc_fwd && (cur_ff == '0) &&
                 (tur_ff == AQP_TURN_NEG_MIN)) begin
      ovf_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // alarms
  // ------------------------------------------------------------------
  // strap is caught on the first clock after reset release, never by reset
  always_ff @(posedge clock) begin
    if (srst) begin
      boot_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b1;
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      sfa_ff <= 1'b0;
    end else if (!boot_ff && first_power_strap) begin
      sfa_ff <= 1'b1;
    end else if (turn_data_clear_command) begin
      sfa_ff <= 1'b0;
    end
  end

  // sticky until reset: the link fault needs a wiring fix, not a clear
  always_ff @(posedge clock) begin
    if (srst) begin
      miss_ff <= '0;
      link_ff <= 1'b0;
    end else if (enc_exchange && enc_rx_ok) begin
      miss_ff <= '0;
    end else if (enc_exchange && (miss_ff != AQP_LINK_MISS_LIMIT)) begin
      miss_ff <= miss_ff + 3'h1;
      if (miss_ff == AQP_LINK_MISS_LIMIT - 3'h1) link_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst || (state_ff == AQP_WAIT) || (state_ff == AQP_GAP1)) begin
      edge_cnt_ff <= '0;
    end else if (burst_step) begin
      edge_cnt_ff <= edge_cnt_ff + 15'h0001;
    end
  end

  property p_boot_alarm;
    @(posedge clock) disable iff (srst)
    (!boot_ff && first_power_strap) |=> system_failure_alarm;
  endproperty
  a_boot_alarm: assert property (p_boot_alarm) else $error("alarm not raised at boot");

  property p_alarm_clear;
    @(posedge clock) disable iff (srst)
    (boot_ff && turn_data_clear_command) |=> !system_failure_alarm;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

  property p_once;
    @(posedge clock) disable iff (srst)
    position_sent |=> position_sent ##1 position_sent;
  endproperty
  a_once: assert property (p_once) else $error("position sent twice");

  property p_turn_dir;
    @(posedge clock) disable iff (srst)
    (state_ff == AQP_TURNS && burst_step) |=>
      ({phase_a, phase_b} == aqp_step($past(ab_ff), !$past(turn_neg)));
  endproperty
  a_turn_dir: assert property (p_turn_dir) else $error("turn burst phase order");

  property p_tick_rate;
    @(posedge clock) disable iff (srst)
    tick |=> (!tick)[*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("edge rate too high");

  property p_pos_dir;
    @(posedge clock) disable iff (srst)
    (state_ff == AQP_POS && burst_step) |=>
      ({phase_a, phase_b} == aqp_step($past(ab_ff), !$past(turn_neg)));
  endproperty
  a_pos_dir: assert property (p_pos_dir) else $error("position burst phase order");

  property p_inc_dir;
    @(posedge clock) disable iff (srst)
    inc_step |=> ({phase_a, phase_b} == aqp_step($past(ab_ff), $past(inc_fwd)));
  endproperty
  a_inc_dir: assert property (p_inc_dir) else $error("incremental phase order");

  property p_rev_wrap;
    @(posedge clock) disable iff (srst)
    (inc_step && inc_fwd && cur_ff == AQP_POS_MAX) |=>
      (cur_ff == '0) && (tur_ff == 13'($past(tur_ff) + 13'h0001));
  endproperty
  a_rev_wrap: assert property (p_rev_wrap) else $error("turn wrap miscounted");

  property p_link;
    @(posedge clock) disable iff (srst)
    (enc_exchange && !enc_rx_ok && miss_ff == 3'h3) |=> encoder_link_error_alarm;
  endproperty
  a_link: assert property (p_link) else $error("link alarm missing");

  property p_turn_count;
    @(posedge clock) disable iff (srst)
    $fell(state_ff == AQP_TURNS) |-> edge_cnt_ff == {aqp_mag(tur_ff), 2'h0};
  endproperty
  a_turn_count: assert property (p_turn_count) else $error("turn burst length");

  property p_pos_count;
    @(posedge clock) disable iff (srst)
    $fell(state_ff == AQP_POS) |-> edge_cnt_ff == {2'h0, cur_ff};
  endproperty
  a_pos_count: assert property (p_pos_count) else $error("position burst length");

  property p_gap_static;
    @(posedge clock) disable iff (srst)
    (state_ff == AQP_GAP1 || state_ff == AQP_GAP2) |=> $stable(ab_ff);
  endproperty
  a_gap_static: assert property (p_gap_static) else $error("phases moved in gap");

  c_neg_turns: cover property (@(posedge clock) disable iff (srst)
    state_ff == AQP_TURNS && turn_neg && burst_step);
  c_sent: cover property (@(posedge clock) disable iff (srst) $rose(position_sent));
  c_fifo_full: cover property (@(posedge clock) disable iff (srst) fifo_full);
  c_link: cover property (@(posedge clock) disable iff (srst) $rose(encoder_link_error_alarm));

endmodule

// ===== test/aqp_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// host controller: decodes quadrature, splits bursts on idle spans
// ----------------------------------------------------------------
module aqp_host_model #(
  parameter int IDLE_SPLIT = 200
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic phase_a,
  input  wire logic phase_b,
  input  wire logic phase_z,
  output int        net [3],
  output int        rises [3],
  output int        z_rises,
  output int        bad_steps
);
  logic [1:0] ab_ff;
  logic       z_ff;
  logic       seen_ff;
  int         idle_ff;
  int         seg_ff;

  // forward order is a rising first: 00 -> 10 -> 11 -> 01
  function automatic logic [1:0] fwd_next(input logic [1:0] ab);
    case (ab)
      2'h0:    return 2'h2;
      2'h2:    return 2'h3;
      2'h3:    return 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      ab_ff     <= 2'h0;
      z_ff      <= 1'b0;
      seen_ff   <= 1'b0;
      idle_ff   <= 0;
      seg_ff    <= 0;
      net       <= '{0, 0, 0};
      rises     <= '{0, 0, 0};
      z_rises   <= 0;
      bad_steps <= 0;
    end else begin
      ab_ff <= {phase_a, phase_b};
      z_ff  <= phase_z;
      if (phase_z && !z_ff) begin
        z_rises <= z_rises + 1;
      end
      if ({phase_a, phase_b} != ab_ff) begin
        idle_ff <= 0;
        seen_ff <= 1'b1;
        // sign from phase order, every a and b edge counted
        if (fwd_next(ab_ff) == {phase_a, phase_b}) begin
          net[seg_ff] <= net[seg_ff] + 1;
        end else if (fwd_next({phase_a, phase_b}) == ab_ff) begin
          net[seg_ff] <= net[seg_ff] - 1;
        end else begin
          bad_steps <= bad_steps + 1;
        end
        if (phase_a && !ab_ff[1]) begin
          rises[seg_ff] <= rises[seg_ff] + 1;
        end
      end else begin
        idle_ff <= idle_ff + 1;
        // a long static span ends a burst; last segment is incremental
        if (seen_ff && idle_ff == IDLE_SPLIT - 1 && seg_ff < 2) begin
          seg_ff  <= seg_ff + 1;
          seen_ff <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== test/aqp_position_output_tb.sv
`timescale 1ns/1ns
module aqp_position_output_tb;
  import aqp_pkg::*;
  localparam int GAP = 400;

  logic        clock;
  logic        srst;
  logic        first_power_strap;
  logic        turn_data_clear_command;
  logic        enc_valid;
  logic [12:0] enc_turns;
  logic [12:0] enc_pos;
  logic        enc_ready;
  logic        enc_exchange;
  logic        enc_rx_ok;
  logic        phase_a;
  logic        phase_b;
  logic        phase_z;
  logic        position_sent;
  logic        system_failure_alarm;
  logic        turn_counter_overflow_alarm;
  logic        encoder_link_error_alarm;
  int          net [3];
  int          rises [3];
  int          z_rises;
  int          bad_steps;
  int          fail_count = 0;
  int          samples_checked = 0;

  aqp_position_output #(.FIFO_DEPTH(16), .GAP_CYC(GAP)) u_aqp_position_output (
    .clock(clock), .srst(srst), .first_power_strap(first_power_strap),
    .turn_data_clear_command(turn_data_clear_command), .enc_valid(enc_valid),
    .enc_turns(enc_turns), .enc_pos(enc_pos), .enc_ready(enc_ready),
    .enc_exchange(enc_exchange), .enc_rx_ok(enc_rx_ok), .phase_a(phase_a),
    .phase_b(phase_b), .phase_z(phase_z), .position_sent(position_sent),
    .system_failure_alarm(system_failure_alarm),
    .turn_counter_overflow_alarm(turn_counter_overflow_alarm),
    .encoder_link_error_alarm(encoder_link_error_alarm));

  aqp_host_model #(.IDLE_SPLIT(200)) u_aqp_host_model (
    .clock(clock), .srst(srst), .phase_a(phase_a), .phase_b(phase_b),
    .phase_z(phase_z), .net(net), .rises(rises), .z_rises(z_rises),
    .bad_steps(bad_steps));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic do_reset(input logic strap);
    first_power_strap = strap;
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(1);
  endtask

  task automatic push(input logic [12:0] t, input logic [12:0] p);
    int i;
    enc_valid = 1'b1;
    enc_turns = t;
    enc_pos = p;
    for (i = 0; i < 5000 && enc_ready !== 1'b1; i++) tick(1);
    check(enc_ready === 1'b1, "sample refused for too long");
    tick(1);
    enc_valid = 1'b0;
  endtask

  task automatic wait_sent();
    int i;
    for (i = 0; i < 8000 && position_sent !== 1'b1; i++) tick(1);
  endtask

  task automatic wait_inc(input int target);
    int i;
    for (i = 0; i < 8000 && net[2] != target; i++) tick(1);
    tick(300);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_alarm();
    check(system_failure_alarm === 1'b1, "alarm not raised at first power");
    check(position_sent === 1'b0 && phase_a === 1'b0, "reset outputs wrong");
    // controller clears the boot alarm with the turn data clear command
    turn_data_clear_command = 1'b1;
    tick(1);
    turn_data_clear_command = 1'b0;
    check(system_failure_alarm === 1'b0, "clear command ignored");
  endtask

  task automatic t_link();
    int k;
    for (k = 0; k < 8; k++) begin
      enc_rx_ok = (k == 3);
      enc_exchange = 1'b1;
      tick(1);
      enc_exchange = 1'b0;
      // a good exchange at k=3 restarts the miss count
      check(encoder_link_error_alarm === (k == 7), "link alarm timing");
      tick(1);
    end
  endtask

  task automatic t_burst_fill();
    int n;
    push(13'h0002, 13'h0005);
    tick(3);
    // targets queue up while bursts run, nothing drains them
    enc_valid = 1'b1;
    enc_pos = 13'h0009;
    for (n = 0; n < 20 && enc_ready === 1'b1; n++) tick(1);
    enc_valid = 1'b0;
    check(n == AQP_FIFO_DEPTH && enc_ready === 1'b0, "fifo did not refuse at 16");
    wait_sent();
    check(position_sent === 1'b1, "bursts never completed");
    check(net[0] == 8 && rises[0] == 2, "turn burst count or phase");
    check(net[1] == 5, "position burst edges");
    wait_inc(4);
    check(net[2] == 4 && rises[2] == 1, "forward incremental step");
    check(enc_ready === 1'b1, "fifo not drained");
    check(bad_steps == 0, "illegal quadrature step");
  endtask

  task automatic t_incremental();
    push(13'h0002, 13'h1ff5);
    wait_inc(-16);
    check(net[2] == -16, "reverse incremental motion");
    check(rises[2] == 6, "pulses per edge ratio");
    check(z_rises == 1, "index pulse at zero crossing");
    check(bad_steps == 0, "illegal step in reverse");
    // forward back across the turn boundary: 8181 to 3 is 14 edges
    push(13'h0002, 13'h0003);
    wait_inc(-2);
    check(net[2] == -2 && bad_steps == 0, "forward motion across wrap");
    check(rises[2] == 9, "forward pulses across wrap");
    check(z_rises == 2, "index pulse on forward wrap");
    check(turn_counter_overflow_alarm === 1'b0, "overflow inside turn range");
  endtask

  task automatic t_reverse_burst();
    do_reset(1'b0);
    check(system_failure_alarm === 1'b0, "alarm without first power");
    check(encoder_link_error_alarm === 1'b0, "link alarm survived reset");
    push(13'h1ffd, 13'h000c);
    wait_sent();
    check(net[0] == -12 && rises[0] == 3, "negative turn burst");
    check(net[1] == -12, "position burst direction");
    tick(2 * GAP);
    check(net[2] == 0 && position_sent === 1'b1, "bursts repeated");
  endtask

  initial begin
    turn_data_clear_command = 1'b0;
    enc_valid = 1'b0;
    enc_turns = 13'h0000;
    enc_pos = 13'h0000;
    enc_exchange = 1'b0;
    enc_rx_ok = 1'b1;
    do_reset(1'b1);
    t_alarm();
    t_link();
    t_burst_fill();
    t_incremental();
    t_reverse_burst();
    conclude();
  end

  // whole run is near 8k cycles; over four times that means a hang
  initial begin
    #(40 * 36000);
    fail_count++;
    conclude();
  end
endmodule
